// [rtl/itc_pkg.sv]
// shared constants, types and helpers of the two-level interrupt controller
package itc_pkg;

    // ------------------------------------------------------------------
    // source numbering, in polling order (0 is polled first)
    // ------------------------------------------------------------------
    localparam int         NUM_SRC   = 11;
    localparam int         SRC_W     = 4;
    localparam logic [3:0] SRC_EXT0  = 4'h0;
    localparam logic [3:0] SRC_TMR0  = 4'h1;
    localparam logic [3:0] SRC_EXT1  = 4'h2;
    localparam logic [3:0] SRC_TMR1  = 4'h3;
    localparam logic [3:0] SRC_SER0  = 4'h4;
    localparam logic [3:0] SRC_TMR2  = 4'h5;
    localparam logic [3:0] SRC_SPI   = 4'h6;
    localparam logic [3:0] SRC_I2C   = 4'h7;
    localparam logic [3:0] SRC_ADC   = 4'h8;
    localparam logic [3:0] SRC_CNT   = 4'h9;
    localparam logic [3:0] SRC_SER1  = 4'ha;

    // ------------------------------------------------------------------
    // bit positions in the enable/priority register pairs
    // ------------------------------------------------------------------
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_EXT0   = 0;
    localparam int BIT_TMR0   = 1;
    localparam int BIT_EXT1   = 2;
    localparam int BIT_TMR1   = 3;
    localparam int BIT_SER0   = 4;
    localparam int BIT_TMR2   = 5;
    localparam int BIT_SPI    = 6;
    localparam int BIT_I2C    = 1;
    localparam int BIT_ADC    = 7;
    localparam int BIT_CNT    = 5;
    localparam int BIT_SER1   = 4;

    // ------------------------------------------------------------------
    // reset values and auto-clear set
    // ------------------------------------------------------------------
    localparam logic [10:0] SAMPLE_RESET = 11'h000;
    localparam logic [15:0] VECTOR_RESET = 16'h0000;
    // timer 0, timer 1, spi and i2c always clear on entry
    localparam logic [10:0] AUTO_CLEAR   = 11'h0ca;

    // ------------------------------------------------------------------
    // vector addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_SER0 = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002b;
    localparam logic [15:0] VEC_ADC  = 16'h003b;
    localparam logic [15:0] VEC_I2C  = 16'h0043;
    localparam logic [15:0] VEC_SER1 = 16'h004b;
    localparam logic [15:0] VEC_SPI  = 16'h0053;
    localparam logic [15:0] VEC_CNT  = 16'h005b;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       ext0_pending_flag;
        logic       timer0_overflow_flag;
        logic       ext1_pending_flag;
        logic       timer1_overflow_flag;
        logic       serial0_receive_flag;
        logic       serial0_transmit_flag;
        logic       timer2_overflow_flag;
        logic       timer2_external_flag;
        logic       spi_tx_end_flag;
        logic       spi_rx_overrun_flag;
        logic       spi_tx_empty_flag;
        logic       spi_rx_full_flag;
        logic       i2c_flag;
        logic       converter_done_flag;
        logic [5:0] counter_match_flags;
        logic [1:0] counter_overflow_flags;
        logic       serial1_receive_flag;
        logic       serial1_transmit_flag;
    } itc_flags_type;

    typedef struct packed {
        logic cycle_start;
        logic last_cycle;
        logic cfg_write;
        logic return_from_interrupt;
    } itc_core_type;

    typedef struct packed {
        logic        long_call;
        logic        high;
        logic [3:0]  source;
        logic [15:0] vector;
    } itc_call_type;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [10:0] flags_or(input itc_flags_type f);
        logic [10:0] r;
        r           = 11'h000;
        r[SRC_EXT0] = f.ext0_pending_flag;
        r[SRC_TMR0] = f.timer0_overflow_flag;
        r[SRC_EXT1] = f.ext1_pending_flag;
        r[SRC_TMR1] = f.timer1_overflow_flag;
        r[SRC_SER0] = f.serial0_receive_flag | f.serial0_transmit_flag;
        r[SRC_TMR2] = f.timer2_overflow_flag | f.timer2_external_flag;
        r[SRC_SPI]  = f.spi_tx_end_flag | f.spi_rx_overrun_flag
                    | f.spi_tx_empty_flag | f.spi_rx_full_flag;
        r[SRC_I2C]  = f.i2c_flag;
        r[SRC_ADC]  = f.converter_done_flag;
        r[SRC_CNT]  = (|f.counter_match_flags) | (|f.counter_overflow_flags);
        r[SRC_SER1] = f.serial1_receive_flag | f.serial1_transmit_flag;
        return r;
    endfunction

    // same bit layout serves both enable and priority pairs
    function automatic logic [10:0] gather(input logic [7:0] base, input logic [7:0] ext);
        logic [10:0] r;
        r           = 11'h000;
        r[SRC_EXT0] = base[BIT_EXT0];
        r[SRC_TMR0] = base[BIT_TMR0];
        r[SRC_EXT1] = base[BIT_EXT1];
        r[SRC_TMR1] = base[BIT_TMR1];
        r[SRC_SER0] = base[BIT_SER0];
        r[SRC_TMR2] = base[BIT_TMR2];
        r[SRC_SPI]  = ext[BIT_SPI];
        r[SRC_I2C]  = ext[BIT_I2C];
        r[SRC_ADC]  = ext[BIT_ADC];
        r[SRC_CNT]  = ext[BIT_CNT];
        r[SRC_SER1] = ext[BIT_SER1];
        return r;
    endfunction

    function automatic logic [15:0] vector_of(input logic [3:0] src);
        logic [15:0] v;
        case (src)
            SRC_EXT0: v = VEC_EXT0;
            SRC_TMR0: v = VEC_TMR0;
            SRC_EXT1: v = VEC_EXT1;
            SRC_TMR1: v = VEC_TMR1;
            SRC_SER0: v = VEC_SER0;
            SRC_TMR2: v = VEC_TMR2;
            SRC_SPI:  v = VEC_SPI;
            SRC_I2C:  v = VEC_I2C;
            SRC_ADC:  v = VEC_ADC;
            SRC_CNT:  v = VEC_CNT;
            SRC_SER1: v = VEC_SER1;
            default:  v = VECTOR_RESET;
        endcase
        return v;
    endfunction

endpackage

// [rtl/itc_poll_pick.sv]
// fixed-order picker: the lowest-numbered request wins
module itc_poll_pick #(
    parameter int N = 11,
    parameter int W = 4
) (
    input  wire logic [N-1:0] req,
    output logic              any,
    output logic [W-1:0]      index
);

    initial
    begin
        if (N < 2 || N > (1 << W))
            $error("itc_poll_pick: N does not fit in the index width");
    end

    assign any = |req;

    always_comb
    begin
        index = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
                index = W'(i);
        end
    end

endmodule

// [rtl/itc_core.sv]
// two-level interrupt controller: sampling, masking, ranking and forced call
module itc_core (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire itc_pkg::itc_flags_type flags,
    input  wire logic                 ext0_edge_mode,
    input  wire logic                 ext1_edge_mode,
    input  wire logic [7:0]           irq_enable_reg,
    input  wire logic [7:0]           irq_enable_ext_reg,
    input  wire logic [7:0]           irq_priority_reg,
    input  wire logic [7:0]           irq_priority_ext_reg,
    input  wire itc_pkg::itc_core_type core,
    output itc_pkg::itc_call_type     call,
    output logic [10:0]               flag_clear,
    output logic                      in_service_high,
    output logic                      in_service_low
);

    // ------------------------------------------------------------------
    // request gathering
    // ------------------------------------------------------------------
    logic [10:0] sampled;
    logic        global_irq_enable;
    logic [10:0] raw_req;
    logic [10:0] src_enable;
    logic [10:0] src_high;
    logic [10:0] eligible;
    logic [10:0] high_req;
    logic [10:0] low_req;

    // reserved slots have no bit in these vectors at all
    assign raw_req           = itc_pkg::flags_or(flags);
    assign global_irq_enable = irq_enable_reg[itc_pkg::BIT_GLOBAL];
    assign src_enable        = itc_pkg::gather(irq_enable_reg, irq_enable_ext_reg);
    assign src_high          = itc_pkg::gather(irq_priority_reg, irq_priority_ext_reg);
    assign eligible          = sampled & src_enable & {11{global_irq_enable}};
    assign high_req          = eligible & src_high;
    assign low_req           = eligible & ~src_high;

    // ------------------------------------------------------------------
    // ranking within each level
    // ------------------------------------------------------------------
    logic       high_any;
    logic [3:0] high_index;
    logic       low_any;
    logic [3:0] low_index;

    itc_poll_pick #(
        .N (itc_pkg::NUM_SRC),
        .W (itc_pkg::SRC_W)
    ) u_pick_high (
        .req   (high_req),
        .any   (high_any),
        .index (high_index)
    );

    itc_poll_pick #(
        .N (itc_pkg::NUM_SRC),
        .W (itc_pkg::SRC_W)
    ) u_pick_low (
        .req   (low_req),
        .any   (low_any),
        .index (low_index)
    );

    // ------------------------------------------------------------------
    // dispatch decision
    // ------------------------------------------------------------------
    logic        step_ok;
    logic        take_high;
    logic        take_low;
    logic        fire;
    logic [3:0]  win_index;
    logic [10:0] win_onehot;
    logic [10:0] edge_mask;
    logic        return_from_interrupt_done;

    // only the final cycle of an instruction that neither touches the
    // mask/priority registers nor returns may be interrupted
    assign step_ok    = core.cycle_start & core.last_cycle & ~core.cfg_write
                      & ~core.return_from_interrupt;
    // a high request only waits on high service, so it preempts low
    assign take_high  = step_ok & high_any & ~in_service_high;
    assign take_low   = step_ok & low_any & ~high_any
                      & ~in_service_high & ~in_service_low;
    assign fire       = take_high | take_low;
    assign win_index  = take_high ? high_index : low_index;
    assign win_onehot = 11'h001 << win_index;
    assign edge_mask  = itc_pkg::AUTO_CLEAR
                      | ({10'h000, ext0_edge_mode} << itc_pkg::SRC_EXT0)
                      | ({10'h000, ext1_edge_mode} << itc_pkg::SRC_EXT1);
    assign return_from_interrupt_done  = core.cycle_start & core.last_cycle
                      & core.return_from_interrupt;

    // ------------------------------------------------------------------
    // sample latch
    // ------------------------------------------------------------------
    // the evaluation above reads the previous sample while the new one
    // is taken, giving the one machine cycle of polling latency
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sampled <= itc_pkg::SAMPLE_RESET;
        else if (core.cycle_start)
            sampled <= raw_req;
    end

    // ------------------------------------------------------------------
    // in-service tracking
    // ------------------------------------------------------------------
    logic next_in_high;
    logic next_in_low;

    // a return unwinds the innermost level; a plain subroutine return
    // is not seen here, so the level stays busy
    assign next_in_high = take_high | (in_service_high & ~return_from_interrupt_done);
    assign next_in_low  = take_low
                        | (in_service_low & ~(return_from_interrupt_done & ~in_service_high));

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            in_service_high <= 1'b0;
            in_service_low  <= 1'b0;
        end
        else
        begin
            in_service_high <= next_in_high;
            in_service_low  <= next_in_low;
        end
    end

    // ------------------------------------------------------------------
    // forced call and flag clear
    // ------------------------------------------------------------------
    // the sequencer pushes only the program counter; the status word is
    // never part of this call, so routines must save it themselves
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            call.long_call <= 1'b0;
            call.high      <= 1'b0;
            call.source    <= 4'h0;
            call.vector    <= itc_pkg::VECTOR_RESET;
            flag_clear     <= 11'h000;
        end
        else
        begin
            call.long_call <= fire;
            flag_clear     <= fire ? (win_onehot & edge_mask) : 11'h000;
            if (fire)
            begin
                call.high   <= take_high;
                call.source <= win_index;
                call.vector <= itc_pkg::vector_of(win_index);
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_step_ok;
        core.cycle_start && core.last_cycle && !core.cfg_write
            && !core.return_from_interrupt;
    endsequence

    sequence s_high_wait;
        s_step_ok ##0 (high_any && !in_service_high);
    endsequence

    a_call_needs_step: assert property (call.long_call |-> $past(step_ok))
        else $error("call issued outside a permitted step");

    a_call_vector_map: assert property (
        call.long_call |-> call.vector == itc_pkg::vector_of(call.source))
        else $error("call vector does not match source");

    a_call_sample_set: assert property (
        call.long_call |-> (($past(sampled) & $past(src_enable))
                            & (11'h001 << call.source)) != 11'h000
                        && $past(global_irq_enable))
        else $error("call from a source not pending or not enabled");

    a_high_preempts: assert property (s_high_wait |=> call.long_call && call.high)
        else $error("high request not dispatched");

    a_low_waits: assert property (
        call.long_call && !call.high
            |-> !$past(in_service_high) && !$past(in_service_low)
                && !$past(high_any))
        else $error("low call while equal or higher busy");

    a_poll_first: assert property (
        call.long_call |-> ((call.high ? $past(high_req) : $past(low_req))
                            & ((11'h001 << call.source) - 11'h001)) == 11'h000)
        else $error("call did not take first source in polling order");

    a_return_from_interrupt_unwinds: assert property (
        return_from_interrupt_done && in_service_high && in_service_low
            |=> !in_service_high && in_service_low)
        else $error("return did not unwind the innermost level");

    a_edge_clear: assert property (
        call.long_call && call.source == itc_pkg::SRC_TMR0
            |-> flag_clear == (11'h001 << itc_pkg::SRC_TMR0))
        else $error("timer 0 flag not cleared on entry");

    a_level_kept: assert property (
        call.long_call && call.source == itc_pkg::SRC_SER0 |-> flag_clear == 11'h000)
        else $error("level source cleared by hardware");

    a_busy_sets: assert property (
        call.long_call |-> (call.high ? in_service_high : in_service_low))
        else $error("in-service level not set after call");

endmodule

// [verif/itc_seq_model.sv]
// sequencer-side model: machine cycle pacing, returns and call stack depth
module itc_seq_model #(
    parameter int MC_LEN = 4
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire itc_pkg::itc_call_type call,
    input  wire logic                  ret_req,
    input  wire logic                  cfg_hold,
    input  wire logic                  mid_instr,
    output itc_pkg::itc_core_type      core,
    output logic                       ret_busy,
    output logic [3:0]                 depth
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] phase;
    logic       ret_now;

    assign core.cycle_start           = (phase == 8'h00);
    assign core.last_cycle            = ~mid_instr;
    assign core.cfg_write             = cfg_hold;
    // routines only ever leave through the interrupt return
    assign core.return_from_interrupt = ret_busy;
    assign ret_now = ret_busy & core.cycle_start & ~mid_instr;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase    <= 8'h00;
            ret_busy <= 1'b0;
            depth    <= 4'h0;
        end
        else
        begin
            phase <= (phase == 8'(MC_LEN - 1)) ? 8'h00 : phase + 8'h01;
            if (ret_req)
                ret_busy <= 1'b1;
            else if (ret_now)
                ret_busy <= 1'b0;
            // two bytes of program counter per call, status word never stacked
            depth <= depth + (call.long_call ? 4'h2 : 4'h0) - (ret_now ? 4'h2 : 4'h0);
        end
    end
endmodule

// [verif/itc_core_tb.sv]
// self-checking bench of the interrupt controller against the sequencer model
module itc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] VEC [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
        16'h002b, 16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
    // bit of each source in {extended, base} register pair
    localparam int POS [11] = '{0, 1, 2, 3, 4, 5, 14, 9, 15, 13, 12};

    logic                   mclk = 1'b0;
    logic                   rst = 1'b1;
    logic [10:0]            pend = 11'h000;
    logic                   alt = 1'b0;
    logic                   ext0_edge_mode = 1'b1;
    logic                   ext1_edge_mode = 1'b0;
    logic [7:0]             irq_enable_reg = 8'h00;
    logic [7:0]             irq_enable_ext_reg = 8'h00;
    logic [7:0]             irq_priority_reg = 8'h00;
    logic [7:0]             irq_priority_ext_reg = 8'h00;
    logic                   ret_req = 1'b0;
    logic                   cfg_hold = 1'b0;
    logic                   mid_instr = 1'b0;
    itc_pkg::itc_flags_type flags;
    itc_pkg::itc_core_type  core;
    itc_pkg::itc_call_type  call;
    logic [10:0]            flag_clear;
    logic                   in_service_high;
    logic                   in_service_low;
    logic                   ret_busy;
    logic [3:0]             depth;
    int                     bad_count = 0;
    int                     num_checks = 0;

    // alt picks the second flag of multi-flag sources except spi, where it picks the first, spi tx end
    function automatic itc_pkg::itc_flags_type mkflags(input logic [10:0] p, input logic a);
        itc_pkg::itc_flags_type f;
        f = '0;
        f.ext0_pending_flag      = p[0];
        f.timer0_overflow_flag   = p[1];
        f.ext1_pending_flag      = p[2];
        f.timer1_overflow_flag   = p[3];
        f.serial0_receive_flag   = p[4] & ~a;
        f.serial0_transmit_flag  = p[4] & a;
        f.timer2_overflow_flag   = p[5] & ~a;
        f.timer2_external_flag   = p[5] & a;
        f.spi_rx_full_flag       = p[6] & ~a;
        f.spi_tx_end_flag        = p[6] & a;
        f.i2c_flag               = p[7];
        f.converter_done_flag    = p[8];
        f.counter_match_flags    = {p[9] & ~a, 5'h00};
        f.counter_overflow_flags = {1'b0, p[9] & a};
        f.serial1_receive_flag   = p[10] & ~a;
        f.serial1_transmit_flag  = p[10] & a;
        return f;
    endfunction

    function automatic logic [15:0] place(input logic [10:0] m);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 11; i++)
            if (m[i])
                r[POS[i]] = 1'b1;
        return r;
    endfunction

    assign flags = mkflags(pend, alt);

    always #2.5 mclk = ~mclk;

    itc_core itc_core_inst (
        .mclk                 (mclk),
        .rst                  (rst),
        .flags                (flags),
        .ext0_edge_mode       (ext0_edge_mode),
        .ext1_edge_mode       (ext1_edge_mode),
        .irq_enable_reg       (irq_enable_reg),
        .irq_enable_ext_reg   (irq_enable_ext_reg),
        .irq_priority_reg     (irq_priority_reg),
        .irq_priority_ext_reg (irq_priority_ext_reg),
        .core                 (core),
        .call                 (call),
        .flag_clear           (flag_clear),
        .in_service_high      (in_service_high),
        .in_service_low       (in_service_low)
    );

    itc_seq_model #(.MC_LEN(4)) itc_seq_model_inst (
        .mclk      (mclk),
        .rst       (rst),
        .call      (call),
        .ret_req   (ret_req),
        .cfg_hold  (cfg_hold),
        .mid_instr (mid_instr),
        .core      (core),
        .ret_busy  (ret_busy),
        .depth     (depth)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic expect_none(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            check(16'(call.long_call), 16'h0000);
        end
    endtask

    task automatic setup(input logic [10:0] en, input logic glob, input logic [10:0] pr);
        @(posedge mclk);
        {irq_enable_ext_reg, irq_enable_reg} <= place(en) | {8'h00, glob, 7'h00};
        {irq_priority_ext_reg, irq_priority_reg} <= place(pr);
    endtask

    task automatic wait_call(input int s, input logic hi, input logic [1:0] svc);
        int          n;
        logic [10:0] cl;
        n = 0;
        @(posedge mclk);
        #1;
        while (call.long_call !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100)
        begin
            bad_count++;
            $display("[ERR] %0t no call", $time);
            results();
        end
        cl = flag_clear;
        check(16'(call.source), 16'(s));
        check(call.vector, VEC[s]);
        check(16'(call.high), 16'(hi));
        check(16'(cl), 16'((11'h0ca | {8'h00, ext1_edge_mode, 1'b0, ext0_edge_mode}) & (11'h001 << s)));
        check(16'({in_service_high, in_service_low}), 16'(svc));
        @(posedge mclk);
        pend <= pend & ~cl;
    endtask

    task automatic do_return(input logic [1:0] svc);
        int n;
        n = 0;
        @(posedge mclk);
        ret_req <= 1'b1;
        @(posedge mclk);
        ret_req <= 1'b0;
        #1;
        while (ret_busy === 1'b1 && n < 50)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(16'(n < 50), 16'h0001);
        if (n >= 50)
            results();
        check(16'({in_service_high, in_service_low}), 16'(svc));
    endtask

    // firmware clears its level flag before returning
    task automatic service(input int i, input logic [1:0] svc);
        @(posedge mclk);
        pend <= pend & ~(11'h001 << i);
        do_return(svc);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check(16'({call.long_call, flag_clear, in_service_high, in_service_low}), 16'h0000);
        check(call.vector, 16'h0000);
        for (int i = 0; i < 11; i++)
        begin
            setup(11'h7ff, 1'b1, i[0] ? 11'h001 << i : 11'h000);
            @(posedge mclk);
            pend <= pend | (11'h001 << i);
            alt <= i[1];
            wait_call(i, i[0], i[0] ? 2'b10 : 2'b01);
            service(i, 2'b00);
        end
        setup(11'h7ff, 1'b1, 11'h000);
        @(posedge mclk);
        pend <= 11'h7ff;
        for (int i = 0; i < 11; i++)
        begin
            wait_call(i, 1'b0, 2'b01);
            service(i, 2'b00);
        end
        setup(11'h7ff, 1'b0, 11'h000);
        @(posedge mclk);
        pend <= 11'h100;
        expect_none(24);
        setup(11'h6ff, 1'b1, 11'h000);
        expect_none(24);
        setup(11'h7ff, 1'b1, 11'h000);
        wait_call(8, 1'b0, 2'b01);
        service(8, 2'b00);
        @(posedge mclk);
        cfg_hold <= 1'b1;
        pend <= 11'h020;
        expect_none(24);
        @(posedge mclk);
        pend <= 11'h000;
        repeat (8) @(posedge mclk);
        cfg_hold <= 1'b0;
        expect_none(24);
        @(posedge mclk);
        mid_instr <= 1'b1;
        pend <= 11'h020;
        expect_none(24);
        @(posedge mclk);
        mid_instr <= 1'b0;
        wait_call(5, 1'b0, 2'b01);
        service(5, 2'b00);
        setup(11'h7ff, 1'b1, 11'h003);
        @(posedge mclk);
        pend <= 11'h010;
        wait_call(4, 1'b0, 2'b01);
        @(posedge mclk);
        pend <= 11'h004;
        expect_none(24);
        @(posedge mclk);
        pend <= 11'h007;
        wait_call(0, 1'b1, 2'b11);
        #1;
        check(16'(depth), 16'h0004);
        do_return(2'b01);
        wait_call(1, 1'b1, 2'b11);
        do_return(2'b01);
        expect_none(24);
        do_return(2'b00);
        wait_call(2, 1'b0, 2'b01);
        service(2, 2'b00);
        results();
    end
endmodule
